// >>> rtl/dac_i2c_map.svh
// Constants for the DAC two-wire front end: addresses, commands, timing
`ifndef DAC_I2C_MAP_SVH
`define DAC_I2C_MAP_SVH
`define DAC_GLOBAL_ADDR 7'h73
`define DAC_CMD_WRITE 4'h0
`define DAC_CMD_UPDATE 4'h1
`define DAC_CMD_WRITE_UPD_ALL 4'h2
`define DAC_CMD_WRITE_UPD 4'h3
`define DAC_CMD_POWER_DOWN 4'h4
`define DAC_CMD_NOP 4'hF
`define DAC_CHAN_ALL 4'hF
`define DAC_DATA_BYTES 3'h3
`define DAC_WORD_BITS 24
`define CLK_PERIOD_NS 10
`define DET_SETTLE_NS 80
`define DET_SETTLE_CYC ((`DET_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCL_PERIOD_NS 2500
`define SCL_QUARTER_CYC (`SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS))
`endif

// >>> rtl/dac_i2c_pkg.sv
// Types shared by both ends of the DAC two-wire link
package dac_i2c_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_RECV = 4'b0010,
    S_ACK = 4'b0100,
    S_UNUSED = 4'b1000
  } slave_state_type;
  typedef enum logic [4:0] {
    D_LOW = 5'b00001,
    D_REL0 = 5'b00010,
    D_HIGH = 5'b00100,
    D_REL1 = 5'b01000,
    D_DONE = 5'b10000
  } det_state_type;
  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_START = 4'b0010,
    M_BIT = 4'b0100,
    M_STOP = 4'b1000
  } mst_state_type;
endpackage

// >>> rtl/dac_i2c_if.sv
// Open-drain two-wire bus joining master and DAC slave
interface dac_i2c_if;
  logic m_scl_o;
  logic m_scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  wire scl;
  wire sda;
  // Pull-ups: a line is low only while some party drives it low
  assign scl = (!m_scl_oe_n && !m_scl_o) ? 1'b0 : 1'b1;
  assign sda = ((!m_sda_oe_n && !m_sda_o) || (!s_sda_oe_n && !s_sda_o)) ? 1'b0 : 1'b1;
  modport master (output m_scl_o, output m_scl_oe_n, output m_sda_o, output m_sda_oe_n, input scl, input sda);
  modport slave (output s_sda_o, output s_sda_oe_n, input scl, input sda);
endinterface

// >>> rtl/dac_i2c_slave.sv
// DAC end: write-only two-wire slave, address pin sensing, channel codes
// Notes on behaviour
// R1 - Sample data on each clock rise
// R2 - Data line released except during acknowledge
// R3 - Idle bus leaves both lines high
// R4 - Data fall with clock high starts
// R5 - Data rise with clock high stops
// R6 - Master clocks and releases acknowledge bit
// R7 - Acknowledge low across whole clock high
// R8 - Receive-only: writes accepted, reads ignored
// R9 - Read request left unacknowledged
// R10 - Three-state pins give 27 addresses
// R11 - Address from pin index formula
// R12 - Fixed global address also answered
// R13 - Global write taken by every device
// R14 - Pins driven to detect floating state
// R15 - Standard variant resets codes zero
// R16 - Midscale variant resets codes midscale
// R17 - Output follows code over two-to-N
// R18 - Address ack only on match and write
// R19 - Ack three bytes then execute word
// R20 - Fourth and later bytes not acknowledged
// R21 - Command, channel, then 16-bit data
// R22 - Start or stop abandons partial word
// R23 - Idle ignores bus until next start
`include "dac_i2c_map.svh"
module dac_i2c_slave #(
  parameter int RES = 16,
  parameter bit MIDSCALE = 1'b0,
  parameter int SETTLE = `DET_SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  dac_i2c_if.slave bus,
  input wire logic [2:0] addr_sel_i,
  output logic [2:0] addr_sel_o,
  output logic [2:0] addr_sel_oe_n_o,
  output logic addr_ready_o,
  output logic [6:0] slave_addr_o,
  output logic word_valid_o,
  output logic [23:0] word_o,
  output logic [4*RES-1:0] dac_code_o,
  output logic [3:0] power_down_o
);
  localparam logic [RES-1:0] RESET_CODE = MIDSCALE ? {1'b1, {(RES-1){1'b0}}} : '0;

  // Low = 0, float = 1, high = 2 from the two released samples
  function automatic logic [1:0] pin_level(input logic s0, input logic s1);
    pin_level = (s0 == s1) ? (s0 ? 2'd2 : 2'd0) : 2'd1;
  endfunction

  function automatic logic [6:0] pins_to_addr(input logic [2:0] s0, input logic [2:0] s1);
    logic [4:0] idx;
    logic [2:0] top;
    idx = 5'(9 * pin_level(s0[2], s1[2]) + 3 * pin_level(s0[1], s1[1]) + pin_level(s0[0], s1[0]));
    top = 3'(idx[4:2] + 3'd1);
    pins_to_addr = {top, 2'b00, idx[1:0]};
  endfunction

  // Address pin sensing
  dac_i2c_pkg::det_state_type det_q;
  logic [7:0] det_cnt_q;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] smp0_q;
  logic [2:0] smp1_q;
  logic [2:0] pin_val_q;
  logic [2:0] pin_oe_n_q;
  logic [6:0] own_addr_q;
  logic det_end;

  assign det_end = det_cnt_q == 8'(SETTLE - 1);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= addr_sel_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  // A floating pin keeps the level last forced, a tied pin does not follow
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      det_q <= dac_i2c_pkg::D_LOW;
      det_cnt_q <= 8'h00;
      pin_oe_n_q <= 3'h0;
      pin_val_q <= 3'h0;
      smp0_q <= 3'h0;
      smp1_q <= 3'h0;
      own_addr_q <= 7'h00;
    end else begin
      det_cnt_q <= (det_end || det_q == dac_i2c_pkg::D_DONE) ? 8'h00 : 8'(det_cnt_q + 8'h01);
      unique case (det_q)
        dac_i2c_pkg::D_LOW: if (det_end) begin
          pin_oe_n_q <= 3'h7; // R14
          det_q <= dac_i2c_pkg::D_REL0;
        end
        dac_i2c_pkg::D_REL0: if (det_end) begin
          smp0_q <= pin_s2_q;
          pin_val_q <= 3'h7;
          pin_oe_n_q <= 3'h0; // R14
          det_q <= dac_i2c_pkg::D_HIGH;
        end
        dac_i2c_pkg::D_HIGH: if (det_end) begin
          pin_oe_n_q <= 3'h7;
          det_q <= dac_i2c_pkg::D_REL1;
        end
        dac_i2c_pkg::D_REL1: if (det_end) begin
          smp1_q <= pin_s2_q;
          det_q <= dac_i2c_pkg::D_DONE;
        end
        dac_i2c_pkg::D_DONE: begin
          pin_val_q <= 3'h0;
          own_addr_q <= pins_to_addr(smp0_q, smp1_q); // R10 R11
        end
        default: det_q <= dac_i2c_pkg::D_LOW;
      endcase
    end
  end

  assign addr_sel_o = pin_val_q;
  assign addr_sel_oe_n_o = pin_oe_n_q;
  assign slave_addr_o = own_addr_q;

  logic ready_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= det_q == dac_i2c_pkg::D_DONE;
    end
  end
  assign addr_ready_o = ready_q;

  // Bus line synchronisers and edge detection
  logic [1:0] scl_sy_q;
  logic [1:0] sda_sy_q;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_sy_q <= 2'h3;
      sda_sy_q <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sy_q <= {scl_sy_q[0], bus.scl};
      sda_sy_q <= {sda_sy_q[0], bus.sda};
      scl_q <= scl_sy_q[1];
      sda_q <= sda_sy_q[1];
    end
  end

  assign scl_rise = scl_sy_q[1] && !scl_q;
  assign scl_fall = !scl_sy_q[1] && scl_q;
  assign start_det = scl_sy_q[1] && scl_q && sda_q && !sda_sy_q[1]; // R4
  assign stop_det = scl_sy_q[1] && scl_q && !sda_q && sda_sy_q[1]; // R5

  // Byte receiver and acknowledge
  dac_i2c_pkg::slave_state_type st_q;
  logic [3:0] bit_q;
  logic [2:0] byte_q;
  logic [7:0] sh_q;
  logic [23:0] word_q;
  logic drive_q;
  logic exec_q;
  logic addr_hit;

  assign addr_hit = sh_q[7:1] == own_addr_q || sh_q[7:1] == `DAC_GLOBAL_ADDR; // R12 R13

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= dac_i2c_pkg::S_IDLE;
      bit_q <= 4'h0;
      byte_q <= 3'h0;
      sh_q <= 8'h00;
      word_q <= 24'h000000;
      drive_q <= 1'b0;
      exec_q <= 1'b0;
    end else begin
      exec_q <= 1'b0;
      if (!ready_q) begin
        st_q <= dac_i2c_pkg::S_IDLE; // R23
      end else if (start_det) begin
        st_q <= dac_i2c_pkg::S_RECV; // R22
        bit_q <= 4'h0;
        byte_q <= 3'h0;
        drive_q <= 1'b0;
      end else if (stop_det) begin
        st_q <= dac_i2c_pkg::S_IDLE; // R22
        drive_q <= 1'b0;
      end else begin
        unique case (st_q)
          dac_i2c_pkg::S_IDLE: drive_q <= 1'b0; // R23
          dac_i2c_pkg::S_RECV: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_sy_q[1]}; // R1
              bit_q <= 4'(bit_q + 4'h1);
            end
            if (scl_fall && bit_q == 4'h8) begin
              if (byte_q == 3'h0) begin
                if (addr_hit && !sh_q[0]) begin
                  st_q <= dac_i2c_pkg::S_ACK; // R18
                  drive_q <= 1'b1; // R7
                end else begin
                  st_q <= dac_i2c_pkg::S_IDLE; // R8 R9 R23
                end
              end else begin
                st_q <= dac_i2c_pkg::S_ACK;
                drive_q <= byte_q <= `DAC_DATA_BYTES; // R19 R20
                if (byte_q <= `DAC_DATA_BYTES) begin
                  word_q <= {word_q[15:0], sh_q}; // R21
                end
              end
            end
          end
          dac_i2c_pkg::S_ACK: if (scl_fall) begin
            // Release on the fall ending the ninth pulse keeps low through high
            drive_q <= 1'b0; // R2 R7
            st_q <= dac_i2c_pkg::S_RECV;
            bit_q <= 4'h0;
            byte_q <= (byte_q == 3'h4) ? byte_q : 3'(byte_q + 3'h1);
            exec_q <= byte_q == `DAC_DATA_BYTES; // R19
          end
          default: st_q <= dac_i2c_pkg::S_IDLE;
        endcase
      end
    end
  end

  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe_n = !drive_q; // R2
  assign word_valid_o = exec_q;
  assign word_o = word_q;

  // Command execution per channel
  logic [3:0] cmd;
  logic [3:0] chan;
  logic [RES-1:0] code;
  assign cmd = word_q[23:20]; // R21
  assign chan = word_q[19:16];
  assign code = word_q[15:16-RES];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_chan
      logic [RES-1:0] in_q;
      logic [RES-1:0] dac_q;
      logic pd_q;
      logic sel;
      assign sel = chan == 4'(g) || chan == `DAC_CHAN_ALL;
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          in_q <= RESET_CODE; // R15 R16
          dac_q <= RESET_CODE; // R15 R16
          pd_q <= 1'b0;
        end else if (exec_q) begin
          if (sel && (cmd == `DAC_CMD_WRITE || cmd == `DAC_CMD_WRITE_UPD_ALL || cmd == `DAC_CMD_WRITE_UPD)) begin
            in_q <= code;
          end
          if (sel && (cmd == `DAC_CMD_UPDATE || cmd == `DAC_CMD_WRITE_UPD)) begin
            dac_q <= (cmd == `DAC_CMD_WRITE_UPD) ? code : in_q;
            pd_q <= 1'b0;
          end else if (cmd == `DAC_CMD_WRITE_UPD_ALL) begin
            dac_q <= sel ? code : in_q;
            pd_q <= 1'b0;
          end else if (sel && cmd == `DAC_CMD_POWER_DOWN) begin
            pd_q <= 1'b1;
          end
        end
      end
      // Analog side makes low_reference + span * code / 2^RES from this
      assign dac_code_o[g*RES +: RES] = dac_q; // R17
      assign power_down_o[g] = pd_q;
    end
  endgenerate
endmodule

// >>> rtl/dac_i2c_master.sv
// Master end: open-drain bus controller that writes the DAC slave
`include "dac_i2c_map.svh"
module dac_i2c_master #(
  parameter int QUARTER = `SCL_QUARTER_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  dac_i2c_if.master bus,
  input wire logic go_i,
  input wire logic [6:0] addr_i,
  input wire logic rd_i,
  input wire logic [2:0] nbytes_i,
  input wire logic [31:0] wdata_i,
  output logic busy_o,
  output logic done_o,
  output logic [4:0] ack_o
);
  dac_i2c_pkg::mst_state_type st_q;
  logic [15:0] q_cnt_q;
  logic tick;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [2:0] left_q;
  logic [2:0] idx_q;
  logic [39:0] sh_q;
  logic scl_rel_q;
  logic sda_rel_q;
  logic [4:0] ack_q;
  logic done_q;
  logic [1:0] sda_sy_q;

  assign tick = q_cnt_q == 16'(QUARTER - 1);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_sy_q <= 2'h3;
      q_cnt_q <= 16'h0000;
    end else begin
      sda_sy_q <= {sda_sy_q[0], bus.sda};
      q_cnt_q <= (st_q == dac_i2c_pkg::M_IDLE || tick) ? 16'h0000 : 16'(q_cnt_q + 16'h0001);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= dac_i2c_pkg::M_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      left_q <= 3'h0;
      idx_q <= 3'h0;
      sh_q <= 40'h0000000000;
      scl_rel_q <= 1'b1;
      sda_rel_q <= 1'b1;
      ack_q <= 5'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (st_q)
        dac_i2c_pkg::M_IDLE: begin
          scl_rel_q <= 1'b1; // R3
          sda_rel_q <= 1'b1;
          if (go_i) begin
            sh_q <= {addr_i, rd_i, wdata_i};
            left_q <= nbytes_i;
            idx_q <= 3'h0;
            ack_q <= 5'h00;
            ph_q <= 2'h0;
            st_q <= dac_i2c_pkg::M_START;
          end
        end
        dac_i2c_pkg::M_START: if (tick) begin
          if (ph_q == 2'h0) begin
            sda_rel_q <= 1'b0; // R4
            ph_q <= 2'h1;
          end else begin
            scl_rel_q <= 1'b0;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            st_q <= dac_i2c_pkg::M_BIT;
          end
        end
        dac_i2c_pkg::M_BIT: if (tick) begin
          ph_q <= 2'(ph_q + 2'h1);
          unique case (ph_q)
            2'h0: sda_rel_q <= (bit_q == 4'h8) ? 1'b1 : sh_q[39]; // R6
            2'h1: scl_rel_q <= 1'b1;
            2'h2: if (bit_q == 4'h8) begin
              ack_q[idx_q] <= !sda_sy_q[1];
            end
            2'h3: begin
              scl_rel_q <= 1'b0;
              if (bit_q == 4'h8) begin
                if (!ack_q[idx_q] || left_q == 3'h0) begin
                  st_q <= dac_i2c_pkg::M_STOP;
                end else begin
                  bit_q <= 4'h0;
                  idx_q <= 3'(idx_q + 3'h1);
                  left_q <= 3'(left_q - 3'h1);
                end
              end else begin
                sh_q <= {sh_q[38:0], 1'b0};
                bit_q <= 4'(bit_q + 4'h1);
              end
            end
            default: ph_q <= 2'h0;
          endcase
        end
        dac_i2c_pkg::M_STOP: if (tick) begin
          ph_q <= 2'(ph_q + 2'h1);
          unique case (ph_q)
            2'h0: sda_rel_q <= 1'b0;
            2'h1: scl_rel_q <= 1'b1;
            2'h2: sda_rel_q <= 1'b1; // R5
            2'h3: begin
              st_q <= dac_i2c_pkg::M_IDLE;
              done_q <= 1'b1;
            end
            default: ph_q <= 2'h0;
          endcase
        end
        default: st_q <= dac_i2c_pkg::M_IDLE;
      endcase
    end
  end

  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe_n = scl_rel_q;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe_n = sda_rel_q;
  assign busy_o = st_q != dac_i2c_pkg::M_IDLE;
  assign done_o = done_q;
  assign ack_o = ack_q;
endmodule

// >>> test/dac_i2c_chk.sv
// Assertions on the open-drain two-wire link between master and DAC slave
module dac_i2c_chk (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic m_scl_o,
  input wire logic m_scl_oe_n,
  input wire logic m_sda_o,
  input wire logic m_sda_oe_n,
  input wire logic s_sda_o,
  input wire logic s_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // Clock rises since the last start, nine per byte
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 4'h0;
    end else if (scl && scl_q && sda_q && !sda) begin
      cnt_q <= 4'h0;
    end else if (scl && !scl_q) begin
      cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
    end
  end
  property p_od_slave;
    s_sda_o == 1'b0;
  endproperty
  a_od_slave: assert property (p_od_slave) else $error("slave data drives high");
  property p_od_master;
    m_scl_o == 1'b0 && m_sda_o == 1'b0;
  endproperty
  a_od_master: assert property (p_od_master) else $error("master drives a line high");
  property p_ack_free;
    (scl && !s_sda_oe_n) |-> m_sda_oe_n;
  endproperty
  a_ack_free: assert property (p_ack_free) else $error("master holds data in ack");
  property p_ack_setup;
    $fell(s_sda_oe_n) |-> !scl;
  endproperty
  a_ack_setup: assert property (p_ack_setup) else $error("ack started with clock high");
  property p_ack_hold;
    (scl && !s_sda_oe_n) |=> (!scl || !s_sda_oe_n);
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped with clock high");
  property p_ack_len;
    $fell(s_sda_oe_n) |-> (!s_sda_oe_n) [*8] ##[1:40] s_sda_oe_n;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack length wrong");
  property p_ack_slot;
    $fell(s_sda_oe_n) |-> cnt_q == 4'h8;
  endproperty
  a_ack_slot: assert property (p_ack_slot) else $error("ack outside ninth bit");
  property p_ack_end;
    $rose(s_sda_oe_n) |-> cnt_q == 4'h0;
  endproperty
  a_ack_end: assert property (p_ack_end) else $error("ack not ended after ninth clock");
endmodule

// >>> test/quad_dac_i2c_slave_front_end_bench.sv
// Bench: master and DAC slave joined by the two-wire link
`include "dac_i2c_map.svh"
module quad_dac_i2c_slave_front_end_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic go = 1'b0;
  logic [6:0] addr = 7'h00;
  logic rd = 1'b0;
  logic [2:0] nb = 3'h0;
  logic [31:0] wd = 32'h0;
  logic busy, done, rdy, wv;
  logic [4:0] ack;
  logic [2:0] pin_i, pin_o, pin_oe_n;
  logic [2:0] hold = 3'h0;
  logic [1:0] mode [3] = '{2'h0, 2'h0, 2'h0};
  logic [6:0] saddr, me;
  logic [23:0] word;
  logic [63:0] code, code2;
  logic [3:0] pd;
  logic [15:0] inp [4];
  logic [15:0] act [4];
  logic [3:0] pdm;
  integer seed = 32'h1598;
  int fails = 0;
  int n_tests = 0;
  int nwv = 0;
  int n0;
  logic [15:0] v;
  dac_i2c_if bus_if();
  dac_i2c_if if2();
  // Twin link: same master traffic, its own slave drive
  assign if2.m_scl_o = bus_if.m_scl_o;
  assign if2.m_scl_oe_n = bus_if.m_scl_oe_n;
  assign if2.m_sda_o = bus_if.m_sda_o;
  assign if2.m_sda_oe_n = bus_if.m_sda_oe_n;
  always #5 clk_i = ~clk_i;
  // Floating pin keeps the level last driven onto it
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      pin_i[k] = (mode[k] == 2'h1) ? (pin_oe_n[k] ? hold[k] : pin_o[k]) : mode[k][1];
    end
  end
  always @(posedge clk_i) hold <= (pin_oe_n & hold) | (~pin_oe_n & pin_o);
  always @(negedge clk_i) if (wv === 1'b1) nwv++;
  dac_i2c_master #(.QUARTER(8)) i_dac_i2c_master (.clk_i(clk_i), .nrst_i(nrst_i), .bus(bus_if),
    .go_i(go), .addr_i(addr), .rd_i(rd), .nbytes_i(nb), .wdata_i(wd), .busy_o(busy), .done_o(done), .ack_o(ack));
  dac_i2c_slave #(.RES(16), .MIDSCALE(1'b0), .SETTLE(8)) i_dac_i2c_slave (.clk_i(clk_i), .nrst_i(nrst_i),
    .bus(bus_if), .addr_sel_i(pin_i), .addr_sel_o(pin_o), .addr_sel_oe_n_o(pin_oe_n), .addr_ready_o(rdy),
    .slave_addr_o(saddr), .word_valid_o(wv), .word_o(word), .dac_code_o(code), .power_down_o(pd));
  // Midscale variant sees the same pins and traffic; only its reset codes are compared
  dac_i2c_slave #(.RES(16), .MIDSCALE(1'b1), .SETTLE(8)) i_dac_i2c_slave_mid (.clk_i(clk_i), .nrst_i(nrst_i),
    .bus(if2), .addr_sel_i(pin_i), .addr_sel_o(), .addr_sel_oe_n_o(), .addr_ready_o(), .slave_addr_o(),
    .word_valid_o(), .word_o(), .dac_code_o(code2), .power_down_o());
  dac_i2c_chk i_dac_i2c_chk (.clk_i(clk_i), .nrst_i(nrst_i), .m_scl_o(bus_if.m_scl_o),
    .m_scl_oe_n(bus_if.m_scl_oe_n), .m_sda_o(bus_if.m_sda_o), .m_sda_oe_n(bus_if.m_sda_oe_n),
    .s_sda_o(bus_if.s_sda_o), .s_sda_oe_n(bus_if.s_sda_oe_n), .scl(bus_if.scl), .sda(bus_if.sda));
  function logic [6:0] exp_addr(input int idx);
    return {3'(idx / 4 + 1), 2'b00, 2'(idx % 4)};
  endfunction
  function logic [63:0] packc();
    return {act[3], act[2], act[1], act[0]};
  endfunction
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task do_reset(input int idx);
    int i;
    me = exp_addr(idx);
    for (int g = 0; g < 4; g++) begin
      inp[g] = 16'h0;
      act[g] = 16'h0;
    end
    pdm = 4'h0;
    @(posedge clk_i);
    nrst_i <= 1'b0;
    // Element k models address pin k
    mode <= '{2'(idx % 3), 2'((idx / 3) % 3), 2'(idx / 9)};
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    chk(64'(pin_oe_n), 64'h0);
    chk(code, packc());
    chk(code2, {4{16'h8000}});
    @(posedge clk_i);
    nrst_i <= 1'b1;
    i = 0;
    while (rdy !== 1'b1 && i < 300) begin
      @(negedge clk_i);
      i++;
    end
    if (i >= 300) begin
      fails++;
      end_sim();
    end
    chk(64'(saddr), 64'(me));
    chk(64'({pin_oe_n, pin_o}), 64'h38);
  endtask
  task xfer(input logic [6:0] a, input logic r, input logic [2:0] n, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    go <= 1'b1;
    addr <= a;
    rd <= r;
    nb <= n;
    wd <= d;
    @(posedge clk_i);
    go <= 1'b0;
    i = 0;
    while (done !== 1'b1 && i < 5000) begin
      @(negedge clk_i);
      i++;
    end
    if (i >= 5000) begin
      fails++;
      end_sim();
    end
    chk(64'({busy, bus_if.scl, bus_if.sda}), 64'h3);
  endtask
  task apply(input logic [3:0] c, input logic [3:0] ch, input logic [15:0] val);
    for (int g = 0; g < 4; g++) begin
      if (ch == 4'(g) || ch == 4'hF) begin
        if (c == 4'h0 || c == 4'h2 || c == 4'h3) inp[g] = val;
        if (c == 4'h1 || c == 4'h3) act[g] = inp[g];
        if (c == 4'h1 || c == 4'h3) pdm[g] = 1'b0;
        if (c == 4'h4) pdm[g] = 1'b1;
      end
      if (c == 4'h2) act[g] = inp[g];
      if (c == 4'h2) pdm[g] = 1'b0;
    end
  endtask
  task wr(input logic [6:0] a, input logic [3:0] c, input logic [3:0] ch);
    v = 16'($random(seed));
    n0 = nwv;
    xfer(a, 1'b0, 3'h3, {c, ch, v, 8'($random(seed))});
    apply(c, ch, v);
    chk(64'(ack), 64'h0F);
    chk(64'(nwv - n0), 64'h1);
    chk(64'(word), 64'({c, ch, v}));
    chk(code, packc());
    chk(64'(pd), 64'(pdm));
  endtask
  initial begin
    // About 16 frames of at most 1500 cycles plus resets, with margin
    #400000;
    fails++;
    end_sim();
  end
  initial begin
    for (int t = 0; t < 6; t++) begin
      do_reset(t == 0 ? 0 : t == 1 ? 26 : {$random(seed)} % 27);
      wr(me, 4'h3, 4'({$random(seed)} % 4));
      $display("address test %0d done", t);
    end
    wr(me, 4'h0, 4'h1);
    wr(me, 4'h1, 4'h1);
    wr(me, 4'h4, 4'h2);
    wr(me, 4'h2, 4'h0);
    wr(me, 4'h3, 4'hF);
    wr(`DAC_GLOBAL_ADDR, 4'h3, 4'hF);
    $display("command test done");
    xfer(me ^ 7'h04, 1'b0, 3'h3, 32'h3F12_3400);
    chk(64'(ack), 64'h0);
    xfer(me, 1'b1, 3'h3, 32'h3F12_3400);
    chk(64'(ack), 64'h0);
    chk(code, packc());
    n0 = nwv;
    xfer(me, 1'b0, 3'h4, 32'h30C3_5AA5);
    apply(4'h3, 4'h0, 16'hC35A);
    chk(64'(ack), 64'h0F);
    chk(64'(word), 64'h30C35A);
    chk(code, packc());
    chk(64'(nwv - n0), 64'h1);
    n0 = nwv;
    xfer(me, 1'b0, 3'h2, 32'h3F77_0000);
    chk(64'(ack), 64'h07);
    chk(64'(nwv - n0), 64'h0);
    chk(code, packc());
    $display("refusal test done");
    end_sim();
  end
endmodule
